/* cmp_pkg.sv */
/*
  Constants and carrier types for the dual comparator control block.
  Assumes an APB master with 32-bit data and byte addressing.
*/
package cmp_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CMP_CTRL_OFS = 8'h00;   // Channel 0 control
  localparam logic [7:0] CMP_VOS_OFS = 8'h04;    // Channel 0 offset control
  localparam logic [7:0] CMP_STRIDE = 8'h08;     // Step between channels
  localparam logic [7:0] CMP_FLAG_OFS = 8'h40;   // Interrupt flags
  localparam logic [7:0] CMP_INTEN_OFS = 8'h44;  // Interrupt enables
  localparam int CMP_ADDR_W = 8;                 // Decoded address bits
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CMP_ON_BIT = 6;       // Control: comparator on
  localparam int CMP_INV_BIT = 5;      // Control: result invert
  localparam int CMP_RES_BIT = 4;      // Control: compare result
  localparam int CMP_SPD_LSB = 2;      // Control: response speed
  localparam int CMP_CAL_BIT = 6;      // Offset: calibration mode
  localparam int CMP_REF_BIT = 5;      // Offset: reference select
  localparam int CMP_TRIM_LSB = 0;     // Offset: trim field
  localparam int CMP_MFE_BIT = 7;      // Enables: multi-function
  localparam int CMP_SPD_W = 2;        // Speed field width
  localparam int CMP_TRIM_W = 5;       // Trim field width
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] CMP_SPD_RST = 2'h0;
  localparam logic [4:0] CMP_TRIM_RST = 5'h10;
  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  // Software control fields of one channel
  typedef struct packed {
    logic on;
    logic invert;
    logic [CMP_SPD_W-1:0] speed;
  } cmp_ctrl_type;
  // Offset calibration fields of one channel
  typedef struct packed {
    logic cal_mode;
    logic cal_ref;
    logic [CMP_TRIM_W-1:0] trim;
  } cmp_vos_type;
  // Controls driven into one analog core
  typedef struct packed {
    logic power_on;
    logic hyst_en;
    logic cal_mode;
    logic cal_ref_pos;
    logic [CMP_SPD_W-1:0] speed;
    logic [CMP_TRIM_W-1:0] trim;
    logic pullup_off;
  } cmp_analog_type;
endpackage

/* cmp_sync.sv */
/*
  Two-stage synchroniser for a vector of asynchronous levels.
  Assumes each bit is an independent level; no word coherence.
*/
`timescale 1ns/1ps
module cmp_sync #(
  parameter int WIDTH = 2
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // ---------------------------------------------------------------
  // Two flip-flop chain
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] meta_reg; // First stage, read by second only
  logic [WIDTH-1:0] sync_reg; // Second stage, safe to use
  // Both stages clear at reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end
  assign sync_out = sync_reg;
endmodule

/* cmp_chan.sv */
/*
  Result shaping and change flag for one comparator channel.
  Assumes the raw comparison is already synchronised to mclk.
*/
`timescale 1ns/1ps
module cmp_chan (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic raw_sync,
  input wire logic on,
  input wire logic invert,
  input wire logic flag_wr,
  input wire logic flag_wdata,
  output logic result,
  output logic change,
  output logic flag
);
  // ---------------------------------------------------------------
  // Result bit
  // ---------------------------------------------------------------
  logic result_reg;  // Polarity-adjusted result
  logic result_next; // Next result value
  logic flag_reg;    // Sticky change flag
  // Off forces low, otherwise apply polarity
  always_comb begin
    result_next = on ? (raw_sync ^ invert) : 1'b0;
  end
  // Result register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      result_reg <= 1'b0;
    end else begin
      result_reg <= result_next;
    end
  end
  // Any change of the shaped bit counts, even one made by invert
  assign change = result_next != result_reg;
  // ---------------------------------------------------------------
  // Change flag
  // ---------------------------------------------------------------
  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flag_reg <= 1'b0;
    end else if (change) begin
      flag_reg <= 1'b1;
    end else if (flag_wr) begin
      flag_reg <= flag_wdata;
    end
  end
  assign result = result_reg;
  assign flag = flag_reg;
endmodule

/* cmp_top.sv */
/*
  Dual comparator control: APB register file, result shaping,
  change flags, interrupt request and wake-up request.
  Assumes an APB master on mclk, asynchronous raw comparator
  outputs, and a low-power indication from logic on mclk.
*/
`timescale 1ns/1ps
module cmp_top
  import cmp_pkg::*;
#(
  parameter int NUM_CH = 2
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_CH-1:0] raw_compare,
  input wire logic low_power,
  output cmp_pkg::cmp_analog_type [NUM_CH-1:0] analog_ctrl,
  output logic [NUM_CH-1:0] compare_result,
  output logic int_req,
  output logic wake_req
);
  import cmp_pkg::*;

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // Enables share one byte with the multi-function bit; flags use the same low bits
  if (NUM_CH < 1 || NUM_CH > CMP_MFE_BIT) begin : g_bad_ch
    $error("NUM_CH out of range");
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  cmp_ctrl_type [NUM_CH-1:0] ctrl_reg; // Control fields per channel
  cmp_vos_type [NUM_CH-1:0] vos_reg;   // Offset fields per channel
  logic [NUM_CH-1:0] int_en_reg;       // Comparator interrupt enables
  logic mfe_reg;                       // Multi-function enable
  logic [NUM_CH-1:0] raw_sync;         // Synchronised raw results
  logic [NUM_CH-1:0] change;           // Shaped result changed
  logic [NUM_CH-1:0] flag;             // Sticky change flags
  logic [NUM_CH-1:0] flag_wr;          // Flag register write strobe
  logic [31:0] prdata_reg;             // Captured read data
  logic [31:0] rd_next;                // Read data mux
  logic err_reg;                       // Captured decode miss
  logic hit_next;                      // Address maps a register
  logic int_reg;                       // Registered request
  logic wake_reg;                      // Registered wake pulse
  logic setup;                         // APB setup cycle
  logic wr_take;                       // Write takes effect
  logic wr_lane0;                      // Low byte lane written
  logic [CMP_ADDR_W-1:0] addr;         // Decoded address bits
  logic [7:0] wbyte;                   // Low write byte

  assign addr = paddr[CMP_ADDR_W-1:0];
  assign wbyte = pwdata[7:0];
  assign setup = psel && !penable;
  // Zero wait states, so every access phase completes
  assign pready = 1'b1;
  assign wr_take = psel && penable && pready && pwrite;
  assign wr_lane0 = wr_take && pstrb[0] && !err_reg;

  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  // The analog edge is free running; detect changes only after this
  cmp_sync #(
    .WIDTH(NUM_CH)
  ) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .async_in(raw_compare),
    .sync_out(raw_sync)
  );

  // ---------------------------------------------------------------
  // Per-channel logic
  // ---------------------------------------------------------------
  // One identical slice per comparator
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    localparam logic [7:0] CTRL_A = 8'(CMP_CTRL_OFS + ch * CMP_STRIDE);
    localparam logic [7:0] VOS_A = 8'(CMP_VOS_OFS + ch * CMP_STRIDE);

    // Result shaping and change flag
    cmp_chan u_chan (
      .mclk(mclk),
      .rstn(rstn),
      .raw_sync(raw_sync[ch]),
      .on(ctrl_reg[ch].on),
      .invert(ctrl_reg[ch].invert),
      .flag_wr(flag_wr[ch]),
      .flag_wdata(wbyte[ch]),
      .result(compare_result[ch]),
      .change(change[ch]),
      .flag(flag[ch])
    );

    // Control register; only bits 6, 5 and 3..2 are stored
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        ctrl_reg[ch].on <= 1'b0;
        ctrl_reg[ch].invert <= 1'b0;
        ctrl_reg[ch].speed <= CMP_SPD_RST;
      end else if (wr_lane0 && addr == CTRL_A) begin
        ctrl_reg[ch].on <= wbyte[CMP_ON_BIT];
        ctrl_reg[ch].invert <= wbyte[CMP_INV_BIT];
        ctrl_reg[ch].speed <= wbyte[CMP_SPD_LSB+:CMP_SPD_W];
      end
    end

    // Offset register; trim resets to mid-scale
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        vos_reg[ch].cal_mode <= 1'b0;
        vos_reg[ch].cal_ref <= 1'b0;
        vos_reg[ch].trim <= CMP_TRIM_RST;
      end else if (wr_lane0 && addr == VOS_A) begin
        vos_reg[ch].cal_mode <= wbyte[CMP_CAL_BIT];
        vos_reg[ch].cal_ref <= wbyte[CMP_REF_BIT];
        vos_reg[ch].trim <= wbyte[CMP_TRIM_LSB+:CMP_TRIM_W];
      end
    end

    // Analog core controls
    // Nothing here looks at low_power: the core keeps running
    always_comb begin
      analog_ctrl[ch].power_on = ctrl_reg[ch].on;
      analog_ctrl[ch].hyst_en = !vos_reg[ch].cal_mode;
      analog_ctrl[ch].cal_mode = vos_reg[ch].cal_mode;
      // Reference choice only matters in calibration mode
      analog_ctrl[ch].cal_ref_pos = vos_reg[ch].cal_mode && vos_reg[ch].cal_ref;
      analog_ctrl[ch].speed = ctrl_reg[ch].speed;
      analog_ctrl[ch].trim = vos_reg[ch].trim;
      analog_ctrl[ch].pullup_off = ctrl_reg[ch].on;
    end

    // Flag write strobe for this channel's bit
    assign flag_wr[ch] = wr_lane0 && addr == CMP_FLAG_OFS;
  end

  // ---------------------------------------------------------------
  // Interrupt enable register
  // ---------------------------------------------------------------
  // Low bits enable channels, bit 7 is the multi-function enable
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      int_en_reg <= '0;
      mfe_reg <= 1'b0;
    end else if (wr_lane0 && addr == CMP_INTEN_OFS) begin
      int_en_reg <= wbyte[NUM_CH-1:0];
      mfe_reg <= wbyte[CMP_MFE_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Interrupt and wake-up requests
  // ---------------------------------------------------------------
  // Request follows the flags one cycle later
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      int_reg <= 1'b0;
    end else begin
      int_reg <= (|(flag & int_en_reg)) && mfe_reg;
    end
  end

  // One-cycle pulse, only for a change on a channel whose flag is
  // still clear; presetting the flag is how software blocks wake-up
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= low_power && (|(change & ~flag));
    end
  end

  assign int_req = int_reg;
  assign wake_req = wake_reg;

  // ---------------------------------------------------------------
  // Read mux and decode
  // ---------------------------------------------------------------
  // Unimplemented bits are left at zero by construction
  always_comb begin
    rd_next = '0;
    hit_next = 1'b0;
    if (addr == CMP_FLAG_OFS) begin
      hit_next = 1'b1;
      rd_next[NUM_CH-1:0] = flag;
    end else if (addr == CMP_INTEN_OFS) begin
      hit_next = 1'b1;
      rd_next[NUM_CH-1:0] = int_en_reg;
      rd_next[CMP_MFE_BIT] = mfe_reg;
    end else begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        if (addr == 8'(CMP_CTRL_OFS + ch * CMP_STRIDE)) begin
          hit_next = 1'b1;
          rd_next[CMP_ON_BIT] = ctrl_reg[ch].on;
          rd_next[CMP_INV_BIT] = ctrl_reg[ch].invert;
          rd_next[CMP_RES_BIT] = compare_result[ch];
          rd_next[CMP_SPD_LSB+:CMP_SPD_W] = ctrl_reg[ch].speed;
        end else if (addr == 8'(CMP_VOS_OFS + ch * CMP_STRIDE)) begin
          hit_next = 1'b1;
          rd_next[CMP_CAL_BIT] = vos_reg[ch].cal_mode;
          rd_next[CMP_REF_BIT] = vos_reg[ch].cal_ref;
          rd_next[CMP_TRIM_LSB+:CMP_TRIM_W] = vos_reg[ch].trim;
        end
      end
    end
    // Upper address bits must be zero for a hit
    if (paddr[31:CMP_ADDR_W] != '0 || paddr[1:0] != 2'h0) begin
      hit_next = 1'b0;
      rd_next = '0;
    end
  end

  // ---------------------------------------------------------------
  // APB capture
  // ---------------------------------------------------------------
  // Read data and decode are caught in the setup cycle and shown
  // in the access phase; the result bit is thus one cycle old
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata_reg <= '0;
      err_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_next;
      err_reg <= !hit_next;
    end
  end

  assign prdata = prdata_reg;
  assign pslverr = psel && penable && err_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  off_forces_low_a: assert property (
    !ctrl_reg[0].on |=> !compare_result[0])
    else $error("result not low while comparator off");

  polarity_path_a: assert property (
    ctrl_reg[0].on |=> compare_result[0] == ($past(raw_sync[0]) ^ $past(ctrl_reg[0].invert)))
    else $error("result polarity wrong");

  change_sets_flag_a: assert property (
    $changed(compare_result[0]) |-> flag[0])
    else $error("result change did not set flag");

  sync_delay_a: assert property (
    ($stable(raw_compare[0]) [*3] ##0 ctrl_reg[0].on && !ctrl_reg[0].invert && $stable(ctrl_reg[0]))
    |=> compare_result[0] == $past(raw_compare[0], 3))
    else $error("result not synchronised in two stages");

  int_gate_a: assert property (
    int_req == $past((|(flag & int_en_reg)) && mfe_reg))
    else $error("interrupt request gating wrong");

  wake_pulse_a: assert property (
    low_power && change[0] && !flag[0] |=> wake_req)
    else $error("no wake request on low power change");

  hyst_cal_a: assert property (
    wr_lane0 && addr == CMP_VOS_OFS && wbyte[CMP_CAL_BIT]
    |=> !analog_ctrl[0].hyst_en ##1 !analog_ctrl[0].hyst_en || $past(wr_lane0))
    else $error("hysteresis still on in calibration");

  pullup_on_a: assert property (
    $rose(ctrl_reg[0].on) |-> analog_ctrl[0].pullup_off && analog_ctrl[0].power_on)
    else $error("pull-ups not dropped on enable");

  ctrl_reserved_a: assert property (
    psel && penable && !pwrite && !pslverr
    |-> prdata[31:8] == '0 && (prdata[7] == 1'b0 || paddr[7:0] == CMP_INTEN_OFS))
    else $error("reserved bits read nonzero");

  trim_reset_a: assert property (
    $rose(rstn) |-> vos_reg[0].trim == CMP_TRIM_RST)
    else $error("trim reset value wrong");

  // Bits 1..0 of a control word are not built and must read zero
  ctrl_low_zero_a: assert property (
    psel && penable && !pwrite && !pslverr && !paddr[6] && !paddr[2]
    |-> prdata[1:0] == 2'h0)
    else $error("control low bits read nonzero");

  // The result bit seen by software is the one captured at setup
  result_read_a: assert property (
    psel && penable && !pwrite && !pslverr && paddr[7:0] == CMP_CTRL_OFS
    |-> prdata[CMP_RES_BIT] == $past(compare_result[0]))
    else $error("result bit read wrong");

  // A hardware set in the cycle of a software clear must survive
  set_beats_clear_a: assert property (
    change[0] && flag_wr[0] |=> flag[0])
    else $error("flag set lost to clear");

  flag_clear_a: assert property (
    flag_wr[0] && !wbyte[0] && !change[0] |=> !flag[0])
    else $error("flag not cleared by write");

  // Wake-up is a low-power event only, and preset flags block it
  wake_only_low_a: assert property (
    !low_power |=> !wake_req)
    else $error("wake request outside low power");

  preset_blocks_wake_a: assert property (
    flag == '1 |=> !wake_req)
    else $error("wake request despite preset flags");

  flag_seen_c: cover property (change[0] ##1 flag[0] ##[1:20] !flag[0]);
  irq_seen_c: cover property (flag[1] && int_en_reg[1] && mfe_reg ##1 int_req);
  wake_seen_c: cover property (low_power ##0 change[1] ##1 wake_req);
  cal_mode_c: cover property (analog_ctrl[0].cal_mode && analog_ctrl[0].cal_ref_pos);
endmodule

/* cmp_core_model.sv */
/*
  Behavioural model of the two analog comparator cores.
  Assumes controls from cmp_top and a target level per channel from the bench.
*/
`timescale 1ns/1ps
module cmp_core_model
  import cmp_pkg::*;
#(
  parameter int NUM_CH = 2
) (
  input wire logic mclk,
  input wire cmp_pkg::cmp_analog_type [NUM_CH-1:0] analog_ctrl,
  input wire logic [NUM_CH-1:0] level,
  input wire logic [NUM_CH-1:0][4:0] cal_point,
  output logic [NUM_CH-1:0] raw_compare
);
  // ---------------------------------------------------------------
  // Comparison per channel
  // ---------------------------------------------------------------
  // Powered-down output means nothing, so it toggles every cycle;
  // an unknown start value resolves to 1 on the first edge
  always @(posedge mclk) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (!analog_ctrl[c].power_on) begin
        raw_compare[c] <= (raw_compare[c] !== 1'b1);
      end else if (analog_ctrl[c].cal_mode) begin
        // Trim above the hidden offset point flips the output
        raw_compare[c] <= (analog_ctrl[c].trim > cal_point[c]);
      end else begin
        raw_compare[c] <= level[c];
      end
    end
  end
endmodule

/* cmp_top_test.sv */
/*
  Self-checking bench for cmp_top against an integer reference model.
  Assumes the APB timing and the 3-edge result latency of the design.
*/
`timescale 1ns/1ps
module cmp_top_test;
  import cmp_pkg::*;
  // ---------------------------------------------------------------
  // Signals and model state
  // ---------------------------------------------------------------
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, low_power = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, int_req, wake_req, err, b;
  logic [1:0] raw, result, level = 2'h0;
  logic [1:0][4:0] cal_point = '0;
  cmp_analog_type [1:0] actl;
  int num_errors = 0, tests_run = 0, wake_cnt = 0, wake_exp = 0, k1, k2;
  logic [7:0] m_ctrl [2], m_vos [2];
  logic [1:0] m_res = '0, m_flag = '0, m_en = '0;
  logic m_mfe = 1'b0;

  always #12.5 mclk = ~mclk;
  // Pulses are counted half a cycle after the edge, where they settle
  always @(negedge mclk) if (wake_req === 1'b1) wake_cnt++;

  cmp_top #(.NUM_CH(2)) cmp_top_i (.mclk(mclk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .raw_compare(raw), .low_power(low_power), .analog_ctrl(actl),
    .compare_result(result), .int_req(int_req), .wake_req(wake_req));
  cmp_core_model #(.NUM_CH(2)) cmp_core_model_i (.mclk(mclk),
    .analog_ctrl(actl), .level(level), .cal_point(cal_point), .raw_compare(raw));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    if (num_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Let results settle, update the model, compare result, analog, request and wake outputs
  task automatic upd();
    logic [4:0] tr;
    logic r;
    logic w;
    repeat (6) @(posedge mclk);
    #1;
    w = 1'b0;
    for (int c = 0; c < 2; c++) begin
      tr = m_vos[c][4:0];
      r = m_ctrl[c][6] & ((m_vos[c][6] ? (tr > cal_point[c]) : level[c]) ^ m_ctrl[c][5]);
      if (r != m_res[c]) begin
        // A change only wakes when the flag was still clear
        if (low_power && !m_flag[c]) w = 1'b1;
        m_flag[c] = 1'b1;
      end
      m_res[c] = r;
      chk(result[c], r, "result");
      chk(actl[c], {m_ctrl[c][6], !m_vos[c][6], m_vos[c][6], m_vos[c][6] & m_vos[c][5],
        m_ctrl[c][3:2], tr, m_ctrl[c][6]}, "analog");
    end
    // Changes in the same cycle share the single request line
    if (w) wake_exp++;
    chk(int_req, |(m_flag & m_en) & m_mfe, "irq");
    chk(wake_cnt, wake_exp, "wake");
  endtask

  // Write with random upper data bits, which must be ignored
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, {24'h0, a}, ($urandom & 32'hFFFF_FF00) | 32'(d));
    case (a)
      8'h00, 8'h08: m_ctrl[a[3]] = d & 8'h6C;
      8'h04, 8'h0C: m_vos[a[3]] = d & 8'h7F;
      8'h40: m_flag = d[1:0];
      8'h44: begin
        m_en = d[1:0];
        m_mfe = d[7];
      end
      default: ;
    endcase
    upd();
  endtask

  task automatic rreg(input logic [7:0] a);
    logic [7:0] e;
    logic ee;
    ee = 1'b0;
    case (a)
      8'h00, 8'h08: e = m_ctrl[a[3]] | {3'h0, m_res[a[3]], 4'h0};
      8'h04, 8'h0C: e = m_vos[a[3]];
      8'h40: e = {6'h0, m_flag};
      8'h44: e = {m_mfe, 5'h0, m_en};
      default: begin
        e = 8'h00;
        ee = 1'b1;
      end
    endcase
    apb(1'b0, {24'h0, a}, 32'h0);
    chk(rd, {24'h0, e}, "rdata");
    chk({31'h0, err}, {31'h0, ee}, "pslverr");
  endtask

  task automatic setlvl(input logic [1:0] v);
    @(posedge mclk);
    level <= v;
    upd();
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  // Turn-on glitches may set flags, so channels power up with flags set
  initial begin
    m_ctrl = '{8'h00, 8'h00};
    m_vos = '{8'h10, 8'h10};
    k1 = $urandom(32'hAF5D);
    cal_point = {5'($urandom_range(28, 2)), 5'($urandom_range(28, 2))};
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    upd();
    for (int a = 0; a < 16; a += 4) rreg(8'(a));
    rreg(8'h10);
    rreg(8'h02);
    // A write with the low byte lane off must leave the register alone
    pstrb <= 4'hE;
    apb(1'b1, 32'h0000_0000, 32'h0000_0040);
    pstrb <= 4'hF;
    rreg(8'h00);
    wreg(8'h10, 8'hFF);
    wreg(8'h40, 8'h03);
    for (int s = 0; s < 4; s++) begin
      wreg(8'h00, 8'hD3 | 8'(s << 2));
      rreg(8'h00);
    end
    for (int i = 0; i < 4; i++) begin
      setlvl(2'(i));
      wreg(8'h00, {2'b01, i[1], 5'h08});
      rreg(8'h00);
    end
    // Calibration sweep on channel 1
    wreg(8'h08, 8'h40);
    wreg(8'h0C, 8'h60);
    rreg(8'h08);
    b = rd[4];
    k1 = 0;
    do begin
      k1++;
      wreg(8'h0C, 8'h60 | 8'(k1));
      rreg(8'h08);
    end while (rd[4] === b && k1 < 31);
    wreg(8'h0C, 8'h7F);
    rreg(8'h08);
    b = rd[4];
    k2 = 31;
    do begin
      k2--;
      wreg(8'h0C, 8'h60 | 8'(k2));
      rreg(8'h08);
    end while (rd[4] === b && k2 > 0);
    chk(k1, cal_point[1] + 1, "sweep up");
    chk(k2, cal_point[1], "sweep down");
    wreg(8'h0C, 8'h20 | 8'((k1 + k2) / 2));
    rreg(8'h0C);
    // Random control words on both channels
    wreg(8'h40, 8'h03);
    for (int i = 0; i < 8; i++) begin
      wreg(8'(8 * (i % 2)), 8'($urandom));
      rreg(8'(8 * (i % 2)));
    end
    wreg(8'h00, 8'h20);
    rreg(8'h00);
    // Flag, request masking and wake-up on channel 0
    wreg(8'h00, 8'h40);
    wreg(8'h40, 8'h00);
    wreg(8'h44, 8'h01);
    setlvl(~level);
    rreg(8'h40);
    wreg(8'h44, 8'h81);
    rreg(8'h44);
    wreg(8'h40, 8'h00);
    @(posedge mclk);
    low_power <= 1'b1;
    setlvl(~level);
    wreg(8'h40, 8'h03);
    setlvl(~level);
    finish_test();
  end
endmodule
